/* File: pkg/link_frame_pkg.sv */
package link_frame_pkg;

   // ------------------------------------------------------------
   // Data path widths
   // ------------------------------------------------------------
   localparam int unsigned BYTE_W = 8;              // One link byte

   // ------------------------------------------------------------
   // Host interface selection
   // ------------------------------------------------------------
   localparam logic [1:0] LINK_SPI  = 2'h0;         // Four-wire serial link
   localparam logic [1:0] LINK_I2C  = 2'h1;         // Two-wire link
   localparam logic [1:0] LINK_UART = 2'h2;         // Asynchronous push link

   // ------------------------------------------------------------
   // Link check byte values
   // ------------------------------------------------------------
   localparam logic [7:0] CHK_CMD      = 8'h30;     // Link check command
   localparam logic [7:0] CHK_FILL     = 8'hFF;     // Filler after the command
   localparam logic [7:0] CHK_OK       = 8'h21;     // Positive answer byte
   localparam logic [7:0] CHK_ZERO     = 8'h00;     // Idle answer byte
   localparam logic [7:0] UART_SYNC    = 8'h55;     // Serial request sync byte
   localparam logic [7:0] UART_CHK_LEN = 8'h02;     // Length of serial check request
   localparam logic [7:0] UART_ANS_LEN = 8'h01;     // Length of serial check answer

   // ------------------------------------------------------------
   // Byte positions and reply counts
   // ------------------------------------------------------------
   localparam logic [2:0] IDX_ZERO     = 3'h0;      // First byte of a frame
   localparam logic [2:0] IDX_STEP     = 3'h1;      // Position increment
   localparam logic [2:0] I2C_ARM_IDX  = 3'h2;      // Write bytes before the read
   localparam logic [2:0] SPI_LAST_IDX = 3'h3;      // Position of the answer byte
   localparam logic [2:0] IDX_SAT      = 3'h4;      // Position counter ceiling
   localparam logic [1:0] REPLY_NONE   = 2'h0;      // No reply queued
   localparam logic [1:0] REPLY_ONE    = 2'h1;      // One reply byte queued
   localparam logic [1:0] REPLY_TWO    = 2'h2;      // Two reply bytes queued
   localparam logic [7:0] FRAME_IDLE   = 8'h00;     // No payload outstanding
   localparam logic [7:0] FRAME_STEP   = 8'h01;     // One payload byte

   // ------------------------------------------------------------
   // Serial check request parser states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      UP_IDLE,
      UP_SYNC,
      UP_CMD,
      UP_FILL
   } uart_parse_t;

endpackage

/* File: verilog/two_entry_byte_buffer.sv */
`timescale 1ns/1ns
module two_entry_byte_buffer (
   input  wire logic                                i_clk_sys,
   input  wire logic                                i_reset_n,
   input  wire logic                                i_in_valid,
   input  wire logic [link_frame_pkg::BYTE_W-1:0]   i_in_data,
   output      logic                                o_in_ready,
   output      logic                                o_out_valid,
   output      logic [link_frame_pkg::BYTE_W-1:0]   o_out_data,
   input  wire logic                                i_out_ready
);

   // ------------------------------------------------------------
   // State: head entry drives the output, second entry absorbs a stall
   // ------------------------------------------------------------
   typedef struct packed {
      logic                              v0;       // Head holds a byte
      logic                              v1;       // Second entry holds a byte
      logic [link_frame_pkg::BYTE_W-1:0] d0;       // Head byte
      logic [link_frame_pkg::BYTE_W-1:0] d1;       // Second byte
   } buf_state_t;

   localparam buf_state_t BUF_RST = '0;

   buf_state_t s_r;                                // Registered state
   buf_state_t s_nxt;                              // Next state
   logic       pop;                                // Head leaves this cycle
   logic       push;                               // New byte enters this cycle

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Ready depends only on the second entry, so the source never sees a
   // combinational path from the sink's ready.
   always_comb begin
      s_nxt = s_r;
      pop   = s_r.v0 && i_out_ready;
      push  = i_in_valid && !s_r.v1;
      if (pop) begin
         // Shift the second entry forward, or refill straight from input
         if (s_r.v1) begin
            s_nxt.d0 = s_r.d1;
            s_nxt.v0 = 1'b1;
            s_nxt.v1 = push;
            if (push) begin
               s_nxt.d1 = i_in_data;
            end
         end else begin
            s_nxt.v0 = push;
            if (push) begin
               s_nxt.d0 = i_in_data;
            end
         end
      end else if (push) begin
         // No drain: fill the head first, then the second entry
         if (!s_r.v0) begin
            s_nxt.d0 = i_in_data;
            s_nxt.v0 = 1'b1;
         end else begin
            s_nxt.d1 = i_in_data;
            s_nxt.v1 = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_r <= BUF_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_in_ready  = !s_r.v1;
   assign o_out_valid = s_r.v0;
   assign o_out_data  = s_r.d0;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_HOLD_WHILE_STALLED: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (o_out_valid && !i_out_ready) |=> (o_out_valid && $stable(o_out_data)))
      else $error("Buffered byte changed or vanished during a stall");

   AST_FULL_REFUSES: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (s_r.v1 && !i_out_ready) |=> (s_r.v1 && !o_in_ready && $stable(s_r.d1)))
      else $error("Full buffer accepted a byte while stalled");

endmodule // two_entry_byte_buffer

/* File: verilog/host_link_frame_receiver.sv */
`timescale 1ns/1ns
module host_link_frame_receiver (
   input  wire logic                                i_clk_sys,
   input  wire logic                                i_reset_n,
   input  wire logic [1:0]                          i_link_sel,
   input  wire logic                                i_frame_start,
   input  wire logic                                i_rx_valid,
   input  wire logic [link_frame_pkg::BYTE_W-1:0]   i_rx_byte,
   input  wire logic                                i_rd_req,
   input  wire logic                                i_out_valid,
   input  wire logic [link_frame_pkg::BYTE_W-1:0]   i_out_byte,
   output      logic                                o_out_ready,
   output      logic                                o_tx_valid,
   output      logic [link_frame_pkg::BYTE_W-1:0]   o_tx_byte,
   input  wire logic                                i_tx_ready,
   output      logic                                o_irq_pending
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      link_frame_pkg::uart_parse_t ust;            // Serial check parser
      logic [2:0]                  idx;            // Byte position in frame
      logic                        chk;            // Check bytes matched so far
      logic [1:0]                  reply_left;     // Reply bytes still queued
      logic [7:0]                  reply_b;        // Next reply byte
      logic                        stage_v;        // Stage holds a byte
      logic [7:0]                  stage_b;        // Staged byte
      logic [7:0]                  frame_left;     // Payload bytes still owed
      logic                        out_rdy;        // Message port ready
      logic                        irq;            // Data pending request
   } frame_state_t;

   localparam frame_state_t FRAME_RST = '0;

   frame_state_t s_r;                              // Registered state
   frame_state_t s_nxt;                            // Next state
   logic         buf_in_ready;                     // Buffer has room
   logic         push;                             // Stage moves into buffer
   logic         stage_free;                       // Stage can load this cycle
   logic         sync_link;                        // Link is not the async one

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt      = s_r;
      sync_link  = (i_link_sel != link_frame_pkg::LINK_UART);
      push       = s_r.stage_v && buf_in_ready;
      stage_free = !s_r.stage_v || push;
      if (push) begin
         s_nxt.stage_v = 1'b0;
      end

      // Synchronous link checks: track position and matched bytes
      if (i_frame_start && sync_link) begin
         s_nxt.idx = link_frame_pkg::IDX_ZERO;
         s_nxt.chk = 1'b0;
      end else if (i_rx_valid && sync_link) begin
         if (s_r.idx == link_frame_pkg::IDX_ZERO) begin
            s_nxt.chk = (i_rx_byte == link_frame_pkg::CHK_CMD);
         end else begin
            s_nxt.chk = s_r.chk && (i_rx_byte == link_frame_pkg::CHK_FILL);
         end
         if (s_r.idx != link_frame_pkg::IDX_SAT) begin
            s_nxt.idx = s_r.idx + link_frame_pkg::IDX_STEP;
         end
         // Full duplex: a shifted byte gets one answer byte only when no reply is queued
         if (i_link_sel == link_frame_pkg::LINK_SPI &&
             s_r.reply_left == link_frame_pkg::REPLY_NONE) begin
            s_nxt.reply_left = link_frame_pkg::REPLY_ONE;
            if (s_r.idx == link_frame_pkg::SPI_LAST_IDX && s_r.chk &&
                i_rx_byte == link_frame_pkg::CHK_FILL) begin
               s_nxt.reply_b = link_frame_pkg::CHK_OK;
            end else begin
               s_nxt.reply_b = link_frame_pkg::CHK_ZERO;
            end
         end
      end else if (i_rd_req && i_link_sel == link_frame_pkg::LINK_I2C &&
                   s_r.reply_left == link_frame_pkg::REPLY_NONE) begin
         // Read after repeated start: one answer byte, 0x21 only for an armed check
         s_nxt.reply_left = link_frame_pkg::REPLY_ONE;
         s_nxt.chk        = 1'b0;
         if (s_r.idx == link_frame_pkg::I2C_ARM_IDX && s_r.chk) begin
            s_nxt.reply_b = link_frame_pkg::CHK_OK;
         end else begin
            s_nxt.reply_b = link_frame_pkg::CHK_ZERO;
         end
      end

      // Async link: parse the four byte check request
      if (i_rx_valid && !sync_link) begin
         s_nxt.ust = (i_rx_byte == link_frame_pkg::UART_SYNC) ?
                     link_frame_pkg::UP_SYNC : link_frame_pkg::UP_IDLE;
         case (s_r.ust)
            link_frame_pkg::UP_SYNC: begin
               if (i_rx_byte == link_frame_pkg::UART_CHK_LEN) begin
                  s_nxt.ust = link_frame_pkg::UP_CMD;
               end
            end
            link_frame_pkg::UP_CMD: begin
               if (i_rx_byte == link_frame_pkg::CHK_CMD) begin
                  s_nxt.ust = link_frame_pkg::UP_FILL;
               end
            end
            link_frame_pkg::UP_FILL: begin
               // Answer is itself a framed message: length one, then 0x21
               if (i_rx_byte == link_frame_pkg::CHK_FILL &&
                   s_r.reply_left == link_frame_pkg::REPLY_NONE) begin
                  s_nxt.reply_left = link_frame_pkg::REPLY_TWO;
                  s_nxt.reply_b    = link_frame_pkg::UART_ANS_LEN;
               end
            end
            default: begin
            end
         endcase
      end

      // Stage loading: message bytes first, replies only between frames
      if (stage_free) begin
         if (s_r.out_rdy && i_out_valid) begin
            s_nxt.stage_v = 1'b1;
            s_nxt.stage_b = i_out_byte;
            if (s_r.frame_left == link_frame_pkg::FRAME_IDLE) begin
               s_nxt.frame_left = i_out_byte;
            end else begin
               s_nxt.frame_left = s_r.frame_left - link_frame_pkg::FRAME_STEP;
            end
         end else if (s_r.reply_left != link_frame_pkg::REPLY_NONE &&
                      s_r.frame_left == link_frame_pkg::FRAME_IDLE) begin
            // A reply never splits an outbound message
            s_nxt.stage_v    = 1'b1;
            s_nxt.stage_b    = s_r.reply_b;
            s_nxt.reply_left = s_r.reply_left - link_frame_pkg::REPLY_ONE;
            s_nxt.reply_b    = link_frame_pkg::CHK_OK;   // Second byte of the async answer is 0x21
         end
      end

      // Message port opens only when the stage will be free next cycle
      s_nxt.out_rdy = !s_nxt.stage_v &&
                      (s_nxt.reply_left == link_frame_pkg::REPLY_NONE ||
                       s_nxt.frame_left != link_frame_pkg::FRAME_IDLE);
      // Request pin only where the host cannot see pushed data
      s_nxt.irq = sync_link && (s_nxt.stage_v || o_tx_valid);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_r <= FRAME_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outbound buffer: absorbs a receiver stall without losing a byte
   // ------------------------------------------------------------
   two_entry_byte_buffer u_out_buf (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_in_valid  (s_r.stage_v),
      .i_in_data   (s_r.stage_b),
      .o_in_ready  (buf_in_ready),
      .o_out_valid (o_tx_valid),
      .o_out_data  (o_tx_byte),
      .i_out_ready (i_tx_ready)
   );

   assign o_out_ready   = s_r.out_rdy;
   assign o_irq_pending = s_r.irq;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_SPI_LAST_ANSWER: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_link_sel == link_frame_pkg::LINK_SPI && i_rx_valid && !i_frame_start &&
       s_r.idx == link_frame_pkg::SPI_LAST_IDX && s_r.chk &&
       i_rx_byte == link_frame_pkg::CHK_FILL && s_r.reply_left == 2'h0)
      |=> (s_r.reply_b == link_frame_pkg::CHK_OK && s_r.reply_left == 2'h1))
      else $error("Serial check did not queue 0x21 on the fourth byte");

   AST_SPI_FILL_ANSWER: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_link_sel == link_frame_pkg::LINK_SPI && i_rx_valid && !i_frame_start &&
       s_r.idx < link_frame_pkg::SPI_LAST_IDX && s_r.reply_left == 2'h0)
      |=> (s_r.reply_b == link_frame_pkg::CHK_ZERO))
      else $error("Serial check answered non-zero before the fourth byte");

   AST_I2C_READ_ANSWER: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_link_sel == link_frame_pkg::LINK_I2C && i_rd_req && !i_rx_valid &&
       !i_frame_start && s_r.idx == link_frame_pkg::I2C_ARM_IDX && s_r.chk &&
       s_r.reply_left == 2'h0)
      |=> (s_r.reply_b == link_frame_pkg::CHK_OK && s_r.reply_left == 2'h1))
      else $error("Two-wire check read did not queue 0x21");

   AST_UART_ANSWER: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_link_sel == link_frame_pkg::LINK_UART && i_rx_valid &&
       s_r.ust == link_frame_pkg::UP_FILL && i_rx_byte == link_frame_pkg::CHK_FILL &&
       s_r.reply_left == 2'h0)
      |=> (s_r.reply_left == 2'h2 && s_r.reply_b == link_frame_pkg::UART_ANS_LEN))
      else $error("Async check did not queue the two byte answer");

   AST_FRAME_LENGTH_TAKEN: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_out_valid && o_out_ready && s_r.frame_left == 8'h00)
      |=> (s_r.frame_left == $past(i_out_byte) && s_r.stage_b == $past(i_out_byte)))
      else $error("Length byte did not set the payload count");

   AST_FRAME_NOT_SPLIT: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (s_r.frame_left != 8'h00 && s_r.reply_left != 2'h0)
      |=> (s_r.reply_left == $past(s_r.reply_left)))
      else $error("Reply byte was inserted inside a message");

   AST_IRQ_ON_PENDING: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_link_sel != link_frame_pkg::LINK_UART && o_tx_valid) |=> o_irq_pending)
      else $error("Pending data without request pin");

   AST_NO_IRQ_ON_PUSH_LINK: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_link_sel == link_frame_pkg::LINK_UART) |=> !o_irq_pending)
      else $error("Request pin raised on the async link");

endmodule // host_link_frame_receiver

/* File: dv/host_phy_model.sv */
`timescale 1ns/1ns
module host_phy_model (
   input  wire logic                              i_clk_sys,
   input  wire logic                              i_reset_n,
   input  wire logic                              i_slow,      // Stall three cycles of four
   input  wire logic                              i_framed,    // Stream is length-framed
   input  wire logic                              i_tx_valid,  // Byte offered by the block
   input  wire logic [link_frame_pkg::BYTE_W-1:0] i_tx_byte,   // Byte to shift out
   output      logic                              o_tx_ready   // Shifter free
);
   // ------------------------------------------------------------
   // Byte sink standing in for the host's receive shifter
   // ------------------------------------------------------------
   logic [1:0] phase_r;                           // Stall pattern phase
   logic [7:0] got [$];                           // Bytes taken, oldest first
   // Receive ring: an eight bit index wraps at the end by itself, so the
   // newest bytes overwrite the oldest ones once the ring is full
   logic [7:0] ring [256];
   logic [7:0] wr_idx_r;
   logic [7:0] start_idx_r;
   logic [7:0] owed_r;                            // Payload bytes still owed
   logic       in_msg_r;                          // Length byte already taken
   logic [7:0] pend_r;                            // Complete messages not yet copied
   logic [7:0] msgs [$];                          // Copied messages, oldest first
   logic [7:0] copy_ptr;                          // Walks the message being copied
   logic       done;                              // A message completed at this edge
   logic       taken;                             // A message was copied at this edge

   // Ready never waits on valid, like a free-running shifter
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_r     <= 2'h0;
         o_tx_ready  <= 1'b0;
         // A host reset forgets every partial or pending message
         wr_idx_r    <= 8'h00;
         start_idx_r <= 8'h00;
         pend_r      <= 8'h00;
         owed_r      <= 8'h00;
         in_msg_r    <= 1'b0;
      end else begin
         phase_r    <= phase_r + 2'h1;
         o_tx_ready <= !i_slow || (phase_r == 2'h3);
         done  = 1'b0;
         taken = 1'b0;
         // Next transfer only after the previous one completed
         if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_byte);
         end
         // Framed stream: store back to back, test completion after every byte
         if (i_tx_valid && o_tx_ready && i_framed) begin
            ring[wr_idx_r] <= i_tx_byte;
            wr_idx_r       <= wr_idx_r + 8'h01;
            done     = in_msg_r ? (owed_r == 8'h01) : (i_tx_byte == 8'h00);
            owed_r   <= in_msg_r ? (owed_r - 8'h01) : i_tx_byte;
            in_msg_r <= !done;
         end
         // Oldest complete message leaves while reception goes on
         if (pend_r != 8'h00) begin
            copy_ptr = start_idx_r;
            for (int k = 0; k <= int'(ring[start_idx_r]); k++) begin
               msgs.push_back(ring[copy_ptr]);
               copy_ptr = copy_ptr + 8'h01;
            end
            start_idx_r <= copy_ptr;
            taken = 1'b1;
         end
         pend_r <= pend_r + 8'(done) - 8'(taken);
      end
   end
endmodule // host_phy_model

/* File: dv/tb_host_link_frame_receiver.sv */
`timescale 1ns/1ns
module tb_host_link_frame_receiver;
   // ------------------------------------------------------------
   // Stimulus, checks and closing report
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  sel;   // Link type
      logic [2:0]  n;     // Request bytes
      logic [31:0] rx;    // Request bytes, first in top byte
      logic        rd;    // Read strobe after the writes
      logic [2:0]  m;     // Answer bytes expected
      logic [31:0] ans;   // Answer bytes, first in top byte
   } row_t;
   logic       i_clk_sys = 1'b0;
   logic       i_reset_n = 1'b0;
   logic [1:0] i_link_sel = 2'h0;
   logic       i_frame_start = 1'b0;
   logic       i_rx_valid = 1'b0;
   logic [7:0] i_rx_byte = 8'h00;
   logic       i_rd_req = 1'b0;
   logic       i_out_valid = 1'b0;
   logic [7:0] i_out_byte = 8'h00;
   logic       slow = 1'b0;
   logic       o_out_ready, o_tx_valid, i_tx_ready, o_irq_pending;
   logic [7:0] o_tx_byte;
   logic       irq_seen = 1'b0;    // Pending flag seen since last clear
   int         miscompares = 0;
   int         cmp_count = 0;
   int         cycles = 0;
   row_t       rows [5];
   // Framed bytes the host should reassemble over the whole run
   localparam logic [111:0] MSG_EXP = 112'h0121_03A0_A1A2_0002_B0B1_0121_0121;

   always #50 i_clk_sys = !i_clk_sys;

   host_link_frame_receiver u_host_link_frame_receiver (.i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n), .i_link_sel(i_link_sel), .i_frame_start(i_frame_start),
      .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_rd_req(i_rd_req),
      .i_out_valid(i_out_valid), .i_out_byte(i_out_byte), .o_out_ready(o_out_ready),
      .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready),
      .o_irq_pending(o_irq_pending));
   host_phy_model u_host_phy_model (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .i_framed(i_link_sel == link_frame_pkg::LINK_UART),
      .i_slow(slow), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
      .o_tx_ready(i_tx_ready));

   // Watch the pending flag; cut a hang short after a generous budget
   always @(posedge i_clk_sys) begin
      if (o_irq_pending === 1'b1) irq_seen = 1'b1;
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle strobe: 0 frame start, 1 received byte, 2 read start
   task automatic strobe(input int which, input logic [7:0] b);
      @(posedge i_clk_sys) #10;
      i_rx_byte = b;
      if (which == 0) i_frame_start = 1'b1;
      else if (which == 1) i_rx_valid = 1'b1;
      else i_rd_req = 1'b1;
      @(posedge i_clk_sys) #10;
      {i_frame_start, i_rx_valid, i_rd_req} = 3'h0;
      repeat (3) @(posedge i_clk_sys);  // Lets the one-deep reply slot drain
   endtask

   // Hold the byte until an edge that sees ready high
   task automatic send_out(input logic [7:0] b);
      @(posedge i_clk_sys) #10;
      i_out_valid = 1'b1;
      i_out_byte = b;
      do @(negedge i_clk_sys); while (o_out_ready !== 1'b1);
      @(posedge i_clk_sys) #10;
      i_out_valid = 1'b0;
   endtask

   task automatic expect_tx(input int m, input logic [39:0] ans);
      repeat (40) @(posedge i_clk_sys);
      check("answer count", 8'(u_host_phy_model.got.size()), 8'(m));
      for (int k = 0; k < m && k < u_host_phy_model.got.size(); k++)
         check("answer byte", u_host_phy_model.got[k], ans[39-8*k -: 8]);
      u_host_phy_model.got.delete();
   endtask

   task automatic run_row(input row_t r);
      @(posedge i_clk_sys) #10;
      i_link_sel = r.sel;
      repeat (2) @(posedge i_clk_sys) #10;
      irq_seen = 1'b0;
      u_host_phy_model.got.delete();
      // Repeated start never pulses frame start, so no stop in between
      if (r.sel != link_frame_pkg::LINK_UART) strobe(0, 8'h00);
      for (int j = 0; j < r.n; j++) strobe(1, r.rx[31-8*j -: 8]);
      if (r.rd) strobe(2, 8'h00);
      expect_tx(r.m, {r.ans, 8'h00});
      check("irq", 8'(irq_seen), 8'(r.sel != link_frame_pkg::LINK_UART));
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      rows[0] = '{2'h0, 3'h4, 32'h30FF_FFFF, 1'b0, 3'h4, 32'h0000_0021};
      rows[1] = '{2'h0, 3'h4, 32'h31FF_FFFF, 1'b0, 3'h4, 32'h0000_0000};
      rows[2] = '{2'h1, 3'h2, 32'h30FF_0000, 1'b1, 3'h1, 32'h2100_0000};
      rows[3] = '{2'h1, 3'h2, 32'h31FF_0000, 1'b1, 3'h1, 32'h0000_0000};
      rows[4] = '{2'h2, 3'h4, 32'h5502_30FF, 1'b0, 3'h2, 32'h0121_0000};
      repeat (10) @(posedge i_clk_sys);
      #10 i_reset_n = 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      // Outbound messages against a stalling host: nothing lost, lengths kept
      #10 slow = 1'b1;
      send_out(8'h03);
      send_out(8'hA0);
      send_out(8'hA1);
      send_out(8'hA2);
      send_out(8'h00);
      expect_tx(5, 40'h03A0_A1A2_00);
      // A check request in mid-message waits for the message to finish
      send_out(8'h02);
      strobe(1, 8'h55);
      strobe(1, 8'h02);
      strobe(1, 8'h30);
      strobe(1, 8'hFF);
      send_out(8'hB0);
      send_out(8'hB1);
      expect_tx(5, 40'h02B0_B101_21);
      #10 slow = 1'b0;
      // Reset in mid-run clears all but the host's copied messages, then a clean check; the length
      // byte below reaches the host first, so its ring must forget it
      send_out(8'h04);
      repeat (4) @(posedge i_clk_sys) #10;
      i_reset_n = 1'b0;
      #10;
      check("ready in reset", 8'(o_out_ready), 8'h00);
      check("valid in reset", 8'(o_tx_valid), 8'h00);
      repeat (2) @(posedge i_clk_sys) #10;
      u_host_phy_model.got.delete();
      i_reset_n = 1'b1;
      @(posedge i_clk_sys) #10;
      check("ready first edge", 8'(o_out_ready), 8'h01);
      @(posedge i_clk_sys) #10;
      check("ready second edge", 8'(o_out_ready), 8'h01);
      run_row(rows[4]);
      // Host side reassembled every framed reply and message, none left over
      check("pending messages", u_host_phy_model.pend_r, 8'h00);
      check("message count", 8'(u_host_phy_model.msgs.size()), 8'h0E);
      for (int k = 0; k < 14 && k < u_host_phy_model.msgs.size(); k++)
         check("message byte", u_host_phy_model.msgs[k], MSG_EXP[111-8*k -: 8]);
      wrap_up();
   end
endmodule // tb_host_link_frame_receiver
